// ==== rtl/olcd_defines.vh ====
// Constants for the OLED command decoder: offsets, opcodes, fields, reset values
// How it works
// - Remap byte bit 4 reverses common lines, bit 6 splits odd/even; 3,5,7 zero
// - A1h with 7-bit parameter sets first displayed RAM row, reset zero
// - A2h with 7-bit parameter sets vertical common offset, reset zero
// - A4h normal, A5h all level 15, A6h all level 0, A7h inverted
// - A8h sets multiplex ratio N+1, reset 127; values 0 to 14 refused
// - ABh bit 0 selects internal regulator (reset) or external logic supply
// - AEh display off and sleep (reset), AFh display on
// - B1h low nibble phase 1, high nibble phase 2; zero length refused
// - B2h and BBh are no-operation commands
// - B3h low nibble clock divide, high nibble oscillator setting, reset zero
// - B5h two-bit pin mode: off, input, drive low (reset), drive high
// - B6h second pre-charge length, reset 4, effective only when enabled
// - B8h takes 15 bytes of 6-bit widths for levels 1 to 15
// - B9h restores linear table: levels 0,1 width 0, then steps of 2
// - BCh four-bit pre-charge code, reset 5; top bit selects common-high level
// - D5h bit 1 enables second pre-charge, bit 0 external segment-low level
// - FDh bit 2 locks; while locked only FDh is obeyed
// - 26h/27h right/left scroll setup with seven parameter bytes
// - Scroll interval code maps to 6,32,64,256,3,4,5,2 frames
// - Select bit low marks command bytes, high marks display data
// - 2Eh stops scrolling; RAM contents must then be rewritten
// - 2Fh starts scrolling only directly after 26h or 27h
`ifndef OLCD_DEFINES_VH
`define OLCD_DEFINES_VH

`define OLCD_ADDR_BYTE    12'h000
`define OLCD_ADDR_STATUS  12'h004
`define OLCD_ADDR_CFG0    12'h008
`define OLCD_ADDR_CFG1    12'h00c
`define OLCD_ADDR_SCRL0   12'h010
`define OLCD_ADDR_SCRL1   12'h014
`define OLCD_ADDR_GSIDX   12'h018
`define OLCD_ADDR_GSVAL   12'h01c

`define OLCD_RESP_OKAY    2'b00
`define OLCD_RESP_SLVERR  2'b10
`define OLCD_DC_BIT       8

`define OLCD_OP_COLADR    8'h15
`define OLCD_OP_ROWADR    8'h75
`define OLCD_OP_CONTRAST  8'h81
`define OLCD_OP_REMAP     8'ha0
`define OLCD_OP_START     8'ha1
`define OLCD_OP_OFFSET    8'ha2
`define OLCD_OP_MODE_HI   6'h29
`define OLCD_OP_MUX       8'ha8
`define OLCD_OP_FUNCA     8'hab
`define OLCD_OP_DISP_HI   7'h57
`define OLCD_OP_PHASE     8'hb1
`define OLCD_OP_NOP_A     8'hb2
`define OLCD_OP_CLKDIV    8'hb3
`define OLCD_OP_GPIO      8'hb5
`define OLCD_OP_PRE2      8'hb6
`define OLCD_OP_GSTAB     8'hb8
`define OLCD_OP_GSLIN     8'hb9
`define OLCD_OP_NOP_B     8'hbb
`define OLCD_OP_VPRE      8'hbc
`define OLCD_OP_COMMON_HIGH_VOLTAGE     8'hbe
`define OLCD_OP_FUNCB     8'hd5
`define OLCD_OP_LOCK      8'hfd
`define OLCD_OP_SCR_R     8'h26
`define OLCD_OP_SCR_L     8'h27
`define OLCD_OP_SCR_OFF   8'h2e
`define OLCD_OP_SCR_ON    8'h2f

`define OLCD_NPAR_ONE     4'd1
`define OLCD_NPAR_ADR     4'd2
`define OLCD_NPAR_GS      4'd15
`define OLCD_NPAR_SCR     4'd7

`define OLCD_REMAP_MASK   8'h57
`define OLCD_LOCK_BIT     2
`define OLCD_PRE2_EN_BIT  1
`define OLCD_MUX_MIN      7'd15
`define OLCD_LEVEL_MAX    4'hf
`define OLCD_LEVEL_MIN    4'h0

`define OLCD_RST_REMAP    8'h00
`define OLCD_RST_START    7'h00
`define OLCD_RST_OFFSET   7'h00
`define OLCD_RST_MUX      7'h7f
`define OLCD_RST_PH1      4'h4
`define OLCD_RST_PH2      4'h7
`define OLCD_RST_CLKDIV   8'h00
`define OLCD_RST_GPIO     2'b10
`define OLCD_RST_PRE2     4'h4
`define OLCD_RST_VPRE     4'h5
`define OLCD_RST_FUNCB    2'b00
`define OLCD_RST_ROW_END  7'h7f
`define OLCD_RST_COL_END  6'h3f

`define OLCD_FR_0         9'd6
`define OLCD_FR_1         9'd32
`define OLCD_FR_2         9'd64
`define OLCD_FR_3         9'd256
`define OLCD_FR_4         9'd3
`define OLCD_FR_5         9'd4
`define OLCD_FR_6         9'd5
`define OLCD_FR_7         9'd2

`endif

// ==== rtl/olcd_command_decoder.v ====
// OLED command decoder with an AXI4-Lite register front end
`timescale 1ns/10ps
`include "olcd_defines.vh"

module olcd_command_decoder #(
  parameter AW = 12                       // AXI address width
) (
  input  wire          ref_clk,           // 250 MHz clock
  input  wire          reset,             // Asynchronous reset, active high
  input  wire [AW-1:0] s_axi_awaddr,      // Write address
  input  wire          s_axi_awvalid,     // Write address valid
  output wire          s_axi_awready,     // Write address ready
  input  wire [31:0]   s_axi_wdata,       // Write data
  input  wire [3:0]    s_axi_wstrb,       // Write byte strobes
  input  wire          s_axi_wvalid,      // Write data valid
  output wire          s_axi_wready,      // Write data ready
  output wire [1:0]    s_axi_bresp,       // Write response
  output wire          s_axi_bvalid,      // Write response valid
  input  wire          s_axi_bready,      // Write response ready
  input  wire [AW-1:0] s_axi_araddr,      // Read address
  input  wire          s_axi_arvalid,     // Read address valid
  output wire          s_axi_arready,     // Read address ready
  output wire [31:0]   s_axi_rdata,       // Read data
  output wire [1:0]    s_axi_rresp,       // Read response
  output wire          s_axi_rvalid,      // Read data valid
  input  wire          s_axi_rready,      // Read data ready
  input  wire [3:0]    pixIn,             // Grey level from display RAM
  output wire [3:0]    pixOut,            // Grey level after display mode
  output wire          displayOn,         // Panel on, not sleeping
  output wire          scrollActive,      // Horizontal scroll running
  output wire [7:0]    memData,           // Display data byte
  output wire          memStb,            // Display data byte strobe
  input  wire          gpioIn,            // General-purpose pin level
  output wire          gpioOut,           // General-purpose pin drive value
  output wire          gpioOeN            // General-purpose pin enable, low drives
);

  // Bus slave state
  reg          awHeld_q;
  reg [AW-1:0] awAddr_q;
  reg          wHeld_q;
  reg [31:0]   wData_q;
  reg [3:0]    wStrb_q;
  reg          bValid_q;
  reg [1:0]    bResp_q;
  reg          rValid_q;
  reg [31:0]   rData_q;
  reg [1:0]    rResp_q;
  reg [3:0]    gsIdx_q;

  // Decoder state
  reg [7:0]    op_q;
  reg [3:0]    cnt_q;
  reg [3:0]    idx_q;
  reg          apply_q;
  reg [7:0]    pb_q [0:14];
  reg [5:0]    gs_q [1:15];
  reg          locked_q;
  reg          armed_q;
  reg          scrollOn_q;
  reg          ramStale_q;
  reg [7:0]    remap_q;
  reg [6:0]    start_q;
  reg [6:0]    offset_q;
  reg [6:0]    mux_q;
  reg [1:0]    mode_q;
  reg          regOn_q;
  reg          dispOn_q;
  reg [3:0]    ph1_q;
  reg [3:0]    ph2_q;
  reg [7:0]    clkDiv_q;
  reg [1:0]    gpio_q;
  reg [3:0]    pre2_q;
  reg [3:0]    vpre_q;
  reg [1:0]    funcB_q;
  reg          scrLeft_q;
  reg [6:0]    rowStart_q;
  reg [6:0]    rowEnd_q;
  reg [5:0]    colStart_q;
  reg [5:0]    colEnd_q;
  reg [2:0]    interval_q;
  reg [7:0]    memData_q;
  reg          memStb_q;
  reg [3:0]    pixOut_q;
  reg          gpioMeta_q;
  reg          gpioSync_q;

  wire         doWrite;
  wire         byteStb;
  wire [7:0]   byteVal;
  wire         byteDc;
  wire         gpioRead;
  wire [3:0]   pre2Eff;
  reg  [31:0]  rdMux;
  reg  [1:0]   rdResp;
  integer      i;

  // Parameter bytes that follow an opcode
  function [3:0] paramCount;
    input [7:0] op;
    begin
      if (op == `OLCD_OP_GSTAB)
        paramCount = `OLCD_NPAR_GS;
      else if (op == `OLCD_OP_SCR_R || op == `OLCD_OP_SCR_L)
        paramCount = `OLCD_NPAR_SCR;
      else if (op == `OLCD_OP_COLADR || op == `OLCD_OP_ROWADR)
        paramCount = `OLCD_NPAR_ADR;
      else if (op == `OLCD_OP_REMAP || op == `OLCD_OP_START || op == `OLCD_OP_OFFSET ||
               op == `OLCD_OP_MUX || op == `OLCD_OP_FUNCA || op == `OLCD_OP_PHASE ||
               op == `OLCD_OP_CLKDIV || op == `OLCD_OP_GPIO || op == `OLCD_OP_PRE2 ||
               op == `OLCD_OP_VPRE || op == `OLCD_OP_FUNCB || op == `OLCD_OP_LOCK ||
               op == `OLCD_OP_CONTRAST || op == `OLCD_OP_COMMON_HIGH_VOLTAGE)
        paramCount = `OLCD_NPAR_ONE;
      else
        paramCount = 4'd0;
    end
  endfunction

  // Linear grey table width of a level
  function [5:0] linearWidth;
    input [3:0] lvl;
    begin
      linearWidth = (lvl == 4'h0) ? 6'h00 : {1'b0, lvl - 4'h1, 1'b0};
    end
  endfunction
  // Frames between scroll steps
  function [8:0] frames;
    input [2:0] code;
    begin
      case (code)
        3'h0: frames = `OLCD_FR_0;
        3'h1: frames = `OLCD_FR_1;
        3'h2: frames = `OLCD_FR_2;
        3'h3: frames = `OLCD_FR_3;
        3'h4: frames = `OLCD_FR_4;
        3'h5: frames = `OLCD_FR_5;
        3'h6: frames = `OLCD_FR_6;
        default: frames = `OLCD_FR_7;
      endcase
    end
  endfunction

  assign s_axi_awready = ~awHeld_q;
  assign s_axi_wready  = ~wHeld_q;
  assign s_axi_bvalid  = bValid_q;
  assign s_axi_bresp   = bResp_q;
  assign s_axi_arready = ~rValid_q;
  assign s_axi_rvalid  = rValid_q;
  assign s_axi_rdata   = rData_q;
  assign s_axi_rresp   = rResp_q;

  // A write is performed once address and data are both held, no response is pending and no parameter apply is under way
  assign doWrite = awHeld_q & wHeld_q & ~bValid_q & ~apply_q;
  assign byteStb = doWrite & (awAddr_q[AW-1:2] == `OLCD_ADDR_BYTE >> 2) & wStrb_q[0];
  assign byteVal = wData_q[7:0];
  assign byteDc  = wStrb_q[1] & wData_q[`OLCD_DC_BIT];

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      awHeld_q <= 1'b0;
      awAddr_q <= {AW{1'b0}};
      wHeld_q  <= 1'b0;
      wData_q  <= 32'h00000000;
      wStrb_q  <= 4'h0;
      bValid_q <= 1'b0;
      bResp_q  <= `OLCD_RESP_OKAY;
      rValid_q <= 1'b0;
      rData_q  <= 32'h00000000;
      rResp_q  <= `OLCD_RESP_OKAY;
      gsIdx_q  <= 4'h0;
    end else begin
      if (s_axi_awvalid && !awHeld_q) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !wHeld_q) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_q <= 1'b0;
        wHeld_q  <= 1'b0;
        bValid_q <= 1'b1;
        bResp_q  <= `OLCD_RESP_OKAY;
        if (awAddr_q[AW-1:2] == `OLCD_ADDR_GSIDX >> 2 && wStrb_q[0]) begin
          gsIdx_q <= wData_q[3:0];
        end else if (awAddr_q[AW-1:2] > `OLCD_ADDR_GSVAL >> 2) begin
          bResp_q <= `OLCD_RESP_SLVERR;
        end
      end else if (bValid_q && s_axi_bready) begin
        bValid_q <= 1'b0;
      end
      if (s_axi_arvalid && !rValid_q) begin
        rValid_q <= 1'b1;
        rData_q  <= rdMux;
        rResp_q  <= rdResp;
      end else if (rValid_q && s_axi_rready) begin
        rValid_q <= 1'b0;
      end
    end
  end

  assign pre2Eff  = funcB_q[`OLCD_PRE2_EN_BIT] ? pre2_q : 4'h0;
  assign gpioRead = (gpio_q == 2'b01) ? gpioSync_q : 1'b0;
  always @* begin
    rdMux  = 32'h00000000;
    rdResp = `OLCD_RESP_OKAY;
    if (s_axi_araddr[AW-1:2] == `OLCD_ADDR_BYTE >> 2) begin
      rdMux = {24'h000000, memData_q};
    end else if (s_axi_araddr[AW-1:2] == `OLCD_ADDR_STATUS >> 2) begin
      rdMux = {24'h000000, gpioRead, ramStale_q, armed_q, scrollOn_q, dispOn_q, locked_q,
               1'b0, cnt_q != 4'd0};
    end else if (s_axi_araddr[AW-1:2] == `OLCD_ADDR_CFG0 >> 2) begin
      rdMux = {remap_q, 1'b0, mux_q, 1'b0, offset_q, 1'b0, start_q};
    end else if (s_axi_araddr[AW-1:2] == `OLCD_ADDR_CFG1 >> 2) begin
      rdMux = {mode_q, vpre_q[3], regOn_q, funcB_q, gpio_q, vpre_q, pre2_q, clkDiv_q,
               ph2_q, ph1_q};
    end else if (s_axi_araddr[AW-1:2] == `OLCD_ADDR_SCRL0 >> 2) begin
      rdMux = {2'b00, colEnd_q, 2'b00, colStart_q, 1'b0, rowEnd_q, 1'b0, rowStart_q};
    end else if (s_axi_araddr[AW-1:2] == `OLCD_ADDR_SCRL1 >> 2) begin
      rdMux = {7'h00, frames(interval_q), 4'h0, pre2Eff, 3'h0, scrLeft_q, 1'b0, interval_q};
    end else if (s_axi_araddr[AW-1:2] == `OLCD_ADDR_GSIDX >> 2) begin
      rdMux = {28'h0000000, gsIdx_q};
    end else if (s_axi_araddr[AW-1:2] == `OLCD_ADDR_GSVAL >> 2) begin
      rdMux = {26'h0, (gsIdx_q == 4'h0) ? 6'h00 : gs_q[gsIdx_q]};
    end else begin
      rdResp = `OLCD_RESP_SLVERR;
    end
  end

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      op_q       <= 8'h00;
      cnt_q      <= 4'd0;
      idx_q      <= 4'd0;
      apply_q    <= 1'b0;
      locked_q   <= 1'b0;
      armed_q    <= 1'b0;
      scrollOn_q <= 1'b0;
      ramStale_q <= 1'b0;
      remap_q    <= `OLCD_RST_REMAP;
      start_q    <= `OLCD_RST_START;
      offset_q   <= `OLCD_RST_OFFSET;
      mux_q      <= `OLCD_RST_MUX;
      mode_q     <= 2'b00;
      regOn_q    <= 1'b1;
      dispOn_q   <= 1'b0;
      ph1_q      <= `OLCD_RST_PH1;
      ph2_q      <= `OLCD_RST_PH2;
      clkDiv_q   <= `OLCD_RST_CLKDIV;
      gpio_q     <= `OLCD_RST_GPIO;
      pre2_q     <= `OLCD_RST_PRE2;
      vpre_q     <= `OLCD_RST_VPRE;
      funcB_q    <= `OLCD_RST_FUNCB;
      scrLeft_q  <= 1'b0;
      rowStart_q <= 7'h00;
      rowEnd_q   <= `OLCD_RST_ROW_END;
      colStart_q <= 6'h00;
      colEnd_q   <= `OLCD_RST_COL_END;
      interval_q <= 3'h0;
      memData_q  <= 8'h00;
      memStb_q   <= 1'b0;
      for (i = 0; i < 15; i = i + 1) begin
        pb_q[i]     <= 8'h00;
        gs_q[i + 1] <= linearWidth(i[3:0] + 4'h1);
      end
    end else begin
      memStb_q <= 1'b0;
      apply_q  <= 1'b0;
      if (byteStb && byteDc) begin
        if (!locked_q) begin
          memData_q  <= byteVal;
          memStb_q   <= 1'b1;
          ramStale_q <= 1'b0;
        end
        cnt_q <= 4'd0;
      end else if (byteStb && cnt_q != 4'd0) begin
        pb_q[idx_q] <= byteVal;
        idx_q       <= idx_q + 4'd1;
        cnt_q       <= cnt_q - 4'd1;
        apply_q     <= (cnt_q == 4'd1);
      end else if (byteStb && (!locked_q || byteVal == `OLCD_OP_LOCK)) begin
        // any other command breaks the setup sequence
        armed_q <= 1'b0;
        if (paramCount(byteVal) != 4'd0) begin
          op_q  <= byteVal;
          cnt_q <= paramCount(byteVal);
          idx_q <= 4'd0;
        end else if (byteVal[7:2] == `OLCD_OP_MODE_HI) begin
          mode_q <= byteVal[1:0];
        end else if (byteVal[7:1] == `OLCD_OP_DISP_HI) begin
          dispOn_q <= byteVal[0];
        end else if (byteVal == `OLCD_OP_GSLIN) begin
          for (i = 1; i < 16; i = i + 1) begin
            gs_q[i] <= linearWidth(i[3:0]);
          end
        end else if (byteVal == `OLCD_OP_SCR_OFF) begin
          scrollOn_q <= 1'b0;
          ramStale_q <= 1'b1;
        end else if (byteVal == `OLCD_OP_SCR_ON) begin
          scrollOn_q <= armed_q;
        end
      end
      if (apply_q) begin
        case (op_q)
          `OLCD_OP_REMAP:  remap_q <= pb_q[0] & `OLCD_REMAP_MASK;
          `OLCD_OP_START:  start_q <= pb_q[0][6:0];
          `OLCD_OP_OFFSET: offset_q <= pb_q[0][6:0];
          `OLCD_OP_MUX:    mux_q <= (pb_q[0][6:0] >= `OLCD_MUX_MIN) ? pb_q[0][6:0] : mux_q;
          `OLCD_OP_FUNCA:  regOn_q <= pb_q[0][0];
          `OLCD_OP_PHASE: begin
            ph1_q <= (pb_q[0][3:0] != 4'h0) ? pb_q[0][3:0] : ph1_q;
            ph2_q <= (pb_q[0][7:4] != 4'h0) ? pb_q[0][7:4] : ph2_q;
          end
          `OLCD_OP_CLKDIV: clkDiv_q <= pb_q[0];
          `OLCD_OP_GPIO:   gpio_q <= pb_q[0][1:0];
          `OLCD_OP_PRE2:   pre2_q <= (pb_q[0][3:0] != 4'h0) ? pb_q[0][3:0] : pre2_q;
          `OLCD_OP_GSTAB: begin
            for (i = 0; i < 15; i = i + 1) begin
              gs_q[i + 1] <= pb_q[i][5:0];
            end
          end
          `OLCD_OP_VPRE:   vpre_q <= pb_q[0][3:0];
          `OLCD_OP_FUNCB:  funcB_q <= pb_q[0][1:0];
          `OLCD_OP_LOCK:   locked_q <= pb_q[0][`OLCD_LOCK_BIT];
          `OLCD_OP_SCR_R, `OLCD_OP_SCR_L: begin
            scrLeft_q  <= op_q[0];
            rowStart_q <= pb_q[1][6:0];
            interval_q <= pb_q[2][2:0];
            rowEnd_q   <= pb_q[3][6:0];
            colStart_q <= pb_q[4][5:0];
            colEnd_q   <= pb_q[5][5:0];
            armed_q    <= 1'b1;
          end
          default: op_q <= op_q;
        endcase
      end
    end
  end

  // Display mode and pin synchroniser
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pixOut_q   <= 4'h0;
      gpioMeta_q <= 1'b0;
      gpioSync_q <= 1'b0;
    end else begin
      gpioMeta_q <= gpioIn;
      gpioSync_q <= gpioMeta_q;
      case (mode_q)
        2'b00:   pixOut_q <= pixIn;
        2'b01:   pixOut_q <= `OLCD_LEVEL_MAX;
        2'b10:   pixOut_q <= `OLCD_LEVEL_MIN;
        default: pixOut_q <= `OLCD_LEVEL_MAX - pixIn;
      endcase
    end
  end

  assign pixOut       = pixOut_q;
  assign displayOn    = dispOn_q;
  assign scrollActive = scrollOn_q;
  assign memData      = memData_q;
  assign memStb       = memStb_q;
  // drive only in modes 10 and 11
  assign gpioOeN      = ~gpio_q[1];
  assign gpioOut      = gpio_q[0];

endmodule // olcd_command_decoder

// ==== tb/olcd_host_model.sv ====
// Host model: AXI4-Lite master feeding command and data bytes
`timescale 1ns/10ps
module olcd_host_model (
  input  wire logic        ref_clk,        // Clock
  output logic      [11:0] s_axi_awaddr,   // Write address
  output logic             s_axi_awvalid,  // Address valid
  input  wire logic        s_axi_awready,  // Address ready
  output logic      [31:0] s_axi_wdata,    // Write data
  output logic      [3:0]  s_axi_wstrb,    // Byte strobes
  output logic             s_axi_wvalid,   // Data valid
  input  wire logic        s_axi_wready,   // Data ready
  input  wire logic [1:0]  s_axi_bresp,    // Write response
  input  wire logic        s_axi_bvalid,   // Response valid
  output logic             s_axi_bready,   // Response ready
  output logic      [11:0] s_axi_araddr,   // Read address
  output logic             s_axi_arvalid,  // Read valid
  input  wire logic        s_axi_arready,  // Read ready
  input  wire logic [31:0] s_axi_rdata,    // Read data
  input  wire logic [1:0]  s_axi_rresp,    // Read response
  input  wire logic        s_axi_rvalid,   // Read data valid
  output logic             s_axi_rready    // Read ready
);
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    s_axi_wstrb = 4'hf;
  end

  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    s_axi_araddr <= ~a;
  endtask
endmodule // olcd_host_model

// ==== tb/olcd_command_decoder_asserts.sv ====
// Port checks for the OLED command decoder
`timescale 1ns/10ps
module olcd_command_decoder_asserts #(
  parameter AW = 12
) (
  input wire logic          ref_clk,        // Clock
  input wire logic          reset,          // Reset
  input wire logic [AW-1:0] s_axi_awaddr,   // Write address
  input wire logic          s_axi_awvalid,  // Address valid
  input wire logic          s_axi_awready,  // Address ready
  input wire logic [31:0]   s_axi_wdata,    // Write data
  input wire logic          s_axi_wvalid,   // Data valid
  input wire logic          s_axi_wready,   // Data ready
  input wire logic [1:0]    s_axi_bresp,    // Write response
  input wire logic          s_axi_bvalid,   // Response valid
  input wire logic          s_axi_bready,   // Response ready
  input wire logic [AW-1:0] s_axi_araddr,   // Read address
  input wire logic          s_axi_arvalid,  // Read valid
  input wire logic          s_axi_arready,  // Read ready
  input wire logic [31:0]   s_axi_rdata,    // Read data
  input wire logic [1:0]    s_axi_rresp,    // Read response
  input wire logic          s_axi_rvalid,   // Read data valid
  input wire logic          s_axi_rready,   // Read ready
  input wire logic          displayOn,      // Panel on
  input wire logic          scrollActive,   // Scroll running
  input wire logic          memStb,         // Data strobe
  input wire logic          gpioOut,        // Pin value
  input wire logic          gpioOeN         // Pin enable
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  wire wrTaken = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;

  AST_WR_ANSWER: assert property (wrTaken |-> ##[2:3] s_axi_bvalid)
    else $error("write response late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_BAD_WR: assert property (wrTaken && s_axi_awaddr[AW-1:2] > 'h7 |-> ##2 s_axi_bresp == 2'b10)
    else $error("unmapped write not refused");
  AST_BAD_RD: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[AW-1:2] > 'h7
    |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  AST_ON_CAUSE: assert property ($rose(displayOn) |-> $past(s_axi_wvalid && s_axi_wdata[8:0] == 9'h0af, 2))
    else $error("display on without command");
  AST_SCR_CAUSE: assert property ($rose(scrollActive)
    |-> $past(s_axi_wvalid && s_axi_wdata[8:0] == 9'h02f, 2))
    else $error("scroll started without command");
  AST_STB_PULSE: assert property (memStb |=> !memStb)
    else $error("data strobe too long");
  AST_RST_OUT: assert property (disable iff (1'b0)
    reset |-> !displayOn && !scrollActive && !memStb && !gpioOeN && !gpioOut)
    else $error("outputs not at reset level");
endmodule // olcd_command_decoder_asserts

// ==== tb/olcd_command_decoder_tb.sv ====
// Self-checking bench for the OLED command decoder
`timescale 1ns/10ps
module olcd_command_decoder_tb;
  logic        ref_clk, reset, gpioIn, displayOn, scrollActive, memStb, gpioOut, gpioOeN;
  logic [3:0]  pixIn, pixOut, s_axi_wstrb;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  memData;
  int          bad_count, checks, cyc, stb;

  olcd_command_decoder dut_u (.*);
  olcd_host_model host_u (.*);

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (memStb) stb++;
    if (cyc == 20000) begin
      bad_count++;
      results();
    end
  end

  task automatic results();
    if (bad_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic send(input logic [7:0] q[$]);
    foreach (q[i]) host_u.wr(12'h000, {24'h0, q[i]}, rs);
  endtask

  task automatic t_reset();
    host_u.rd(12'h008, rv, rs);
    chk(rv, 32'h007f0000);
    host_u.rd(12'h00c, rv, rs);
    chk(rv, 32'h12540074);
    chk({gpioOeN, gpioOut, displayOn, scrollActive}, 32'h0);
  endtask

  task automatic t_cfg();
    send('{8'ha0, 8'hff, 8'ha1, 8'h7f, 8'ha2, 8'h10, 8'ha8, 8'h0e});
    host_u.rd(12'h008, rv, rs);
    chk(rv, 32'h577f107f);
    send('{8'ha8, 8'h0f});
    host_u.rd(12'h008, rv, rs);
    chk(rv, 32'h570f107f);
    send('{8'hb1, 8'h30, 8'hb3, 8'ha5, 8'hb2, 8'hbb, 8'hab, 8'h00, 8'hbc, 8'h09});
    host_u.rd(12'h00c, rv, rs);
    chk(rv, 32'h2294a534);
  endtask

  task automatic t_mode();
    logic [3:0] pm [4] = '{4'h3, 4'hf, 4'h0, 4'hc};
    pixIn <= 4'h3;
    for (int i = 0; i < 4; i++) begin
      send('{8'(8'ha4 + i)});
      repeat (2) @(posedge ref_clk);
      chk(pixOut, pm[i]);
    end
    send('{8'ha4, 8'haf});
    chk(displayOn, 1'b1);
    send('{8'hae});
    chk(displayOn, 1'b0);
    send('{8'haf});
  endtask

  task automatic t_gpio();
    gpioIn <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      send('{8'hb5, 8'(m)});
      repeat (3) @(posedge ref_clk);
      host_u.rd(12'h004, rv, rs);
      chk(gpioOeN, m < 2);
      if (m < 2) chk(rv[7], m[0]);
      else chk(gpioOut, m[0]);
    end
  endtask

  task automatic t_grey();
    logic [7:0] q[$];
    q = '{8'hb8};
    // widths rise and top level exceeds both phases
    for (int i = 1; i < 16; i++) q.push_back(8'(2 * i + 10));
    send(q);
    host_u.wr(12'h018, 32'd15, rs);
    host_u.rd(12'h01c, rv, rs);
    chk(rv, 32'd40);
    host_u.wr(12'h018, 32'd5, rs);
    host_u.rd(12'h01c, rv, rs);
    chk(rv, 32'd20);
    send('{8'hb9});
    host_u.rd(12'h01c, rv, rs);
    chk(rv, 32'd8);
  endtask

  task automatic t_pre2();
    send('{8'hb6, 8'h09});
    host_u.rd(12'h014, rv, rs);
    chk(rv[11:8], 4'h0);
    send('{8'hd5, 8'h03, 8'hb6, 8'h00});
    host_u.rd(12'h014, rv, rs);
    chk(rv[11:8], 4'h9);
    host_u.rd(12'h00c, rv, rs);
    chk(rv[27:26], 2'b11);
  endtask

  task automatic t_scroll();
    logic [8:0] fr [8] = '{9'd6, 9'd32, 9'd64, 9'd256, 9'd3, 9'd4, 9'd5, 9'd2};
    for (int c = 0; c < 8; c++) begin
      // rows and columns in range and ordered
      send('{8'(8'h26 + c % 2), 8'h00, 8'h01, 8'(c), 8'h7e, 8'h02, 8'h3d, 8'h00});
      host_u.rd(12'h014, rv, rs);
      chk({rv[24:16], rv[4], rv[2:0]}, {fr[c], c[0], c[2:0]});
    end
    send('{8'h2f});
    chk(scrollActive, 1'b1);
    host_u.rd(12'h010, rv, rs);
    chk(rv, 32'h3d027e01);
    send('{8'h2e});
    host_u.rd(12'h004, rv, rs);
    chk({scrollActive, rv[6]}, 2'b01);
    send('{8'h2f});
    chk(scrollActive, 1'b0);
  endtask

  task automatic t_lock();
    int n;
    send('{8'hfd, 8'h16, 8'hae});
    host_u.wr(12'h000, 32'h15a, rs);
    host_u.rd(12'h004, rv, rs);
    chk({rv[2], displayOn}, 2'b11);
    n = stb;
    send('{8'hfd, 8'h12});
    host_u.wr(12'h000, 32'h1c3, rs);
    @(posedge ref_clk);
    chk(stb, n + 1);
    chk(memData, 8'hc3);
    host_u.wr(12'h040, 32'h0, rs);
    chk(rs, 2'b10);
    host_u.rd(12'h040, rv, rs);
    chk({rs, rv}, {2'b10, 32'h0});
  endtask

  initial begin
    reset <= 1'b1;
    gpioIn = 1'b0;
    pixIn = 4'h0;
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    t_reset();
    t_cfg();
    t_mode();
    t_gpio();
    t_grey();
    t_pre2();
    t_scroll();
    t_lock();
    results();
  end
endmodule // olcd_command_decoder_tb

bind olcd_command_decoder olcd_command_decoder_asserts #(.AW(AW)) chk_u (.*);
